// *** src/irq_cfg.svh ***
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// ==========================================================
// flag positions in the request flag vector
`define FLG_UART    4'h0
`define FLG_T1A     4'h1
`define FLG_T1P     4'h2
`define FLG_MF      4'h3
`define FLG_LVD     4'h4
`define FLG_EE      4'h5
`define FLG_T0A     4'h6
`define FLG_T0P     4'h7
`define FLG_PA      4'h8
`define FLG_PP      4'h9
`define NUM_FLAGS   10
`define NUM_UART_EV 6

// ==========================================================
// vector addresses, ascending order is service priority
`define VEC_LVD     8'h08
`define VEC_EE      8'h0C
`define VEC_T0A     8'h10
`define VEC_T0P     8'h14
`define VEC_PA      8'h18
`define VEC_PP      8'h1C
`define VEC_MF      8'h20
`define VEC_NONE    8'h00

// ==========================================================
// reset values
`define RST_FLAGS   10'h000
`define RST_GIE     1'b0

`endif

// *** src/irq_pkg.sv ***
package irq_pkg;

  // ==========================================================
  // state of the uart request merger
  typedef struct packed {
    logic [5:0] cond_prev;
    logic       irq_n;
  } merge_state_t;

  // ==========================================================
  // state of the interrupt logic
  typedef struct packed {
    logic       lvd_sync1;
    logic       lvd_sync2;
    logic       gie;
    logic [9:0] flags;
    logic [9:0] flags_prev;
    logic       call_req;
    logic [7:0] vector;
    logic       push_pc;
    logic       pop_pc;
    logic       wake;
    logic       pending;
  } irq_state_t;

endpackage

// *** src/uart_irq_merge.sv ***
`include "irq_cfg.svh"

module uart_irq_merge import irq_pkg::*; #(
  parameter int NUM_EV = `NUM_UART_EV
) (
  input  wire logic              ref_clk_i,    // system clock
  input  wire logic              rstn_i,       // sync reset, active low
  input  wire logic [NUM_EV-1:0] uart_cond_i,  // uart interrupt conditions, levels
  output logic                   uart_irq_n_o  // one-cycle low pulse on a new condition
);

  merge_state_t s_q;
  merge_state_t s_d;

  // ==========================================================
  // pulse, not level: a condition that stays up must not re-request
  always_comb begin
    s_d           = s_q;
    s_d.cond_prev = uart_cond_i;
    s_d.irq_n     = ~(|(uart_cond_i & ~s_q.cond_prev));
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_q <= '{cond_prev: 6'h00, irq_n: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign uart_irq_n_o = s_q.irq_n;

endmodule

// *** src/peripheral_interrupt_logic.sv ***
// What this block does
// - uart requests on tx empty, tx idle, rx data, overrun, address, rx wake-up
// - uart signals the interrupt logic with an active-low pulse
// - uart vectors to shared location only with global, uart and shared enables
// - uart service clears global enable and shared flag, uart flag stays set
// - uart event status bits are never cleared by servicing
// - supply low flag sets whenever the detector reports low supply
// - supply low vectors with global and own enable; service clears flag and global
// - eeprom flag sets at the end of every write cycle
// - eeprom vectors with global and own enable; service clears flag and global
// - each timer has compare A and compare P flags with own enables
// - timer 1 goes through shared vector; timer 0 and periodic own vectors
// - timer 1 vectors with global, own, shared enables; service clears shared flag and global, timer 1 flag stays set
// - timer 0 and periodic service clears their flag and global enable
// - a request calls only while the return stack is not full, else pends
// - any flag rising wakes from sleep or idle, enabled or not
// - a set flag stays set until serviced or cleared by software
// - vectoring pushes only the program counter
// - interrupt exit restores pc and sets global enable; plain return leaves it
// - shared flag sets whenever a member flag goes from clear to set
`include "irq_cfg.svh"

module peripheral_interrupt_logic import irq_pkg::*; #(
  parameter int NFLG   = `NUM_FLAGS,
  parameter int NUEV   = `NUM_UART_EV,
  parameter int VEC_W  = 8
) (
  input  wire logic             ref_clk_i,                  // system clock, 200 MHz
  input  wire logic             rstn_i,                     // sync reset, active low
  // peripheral events
  input  wire logic [NUEV-1:0]  uart_cond_i,                // uart condition levels
  input  wire logic             supply_low_detector_i,      // low supply level, async
  input  wire logic             eeprom_write_end_i,         // write cycle end pulse
  input  wire logic             timer0_match_a_i,           // timer 0 compare A pulse
  input  wire logic             timer0_match_p_i,           // timer 0 compare P pulse
  input  wire logic             timer1_match_a_i,           // timer 1 compare A pulse
  input  wire logic             timer1_match_p_i,           // timer 1 compare P pulse
  input  wire logic             periodic_match_a_i,         // periodic compare A pulse
  input  wire logic             periodic_match_p_i,         // periodic compare P pulse
  // software control
  input  wire logic [NFLG-1:0]  flag_set_i,                 // software sets flags
  input  wire logic [NFLG-1:0]  flag_clr_i,                 // software clears flags
  input  wire logic [NFLG-1:0]  irq_enable_i,               // per flag enables
  input  wire logic             global_irq_enable_set_i,    // software sets global enable
  input  wire logic             global_irq_enable_clr_i,    // software clears global enable
  // core sequencer
  input  wire logic             core_ready_i,               // instruction boundary
  input  wire logic             stack_full_i,               // return stack full
  input  wire logic             irq_exit_reenable_i,        // interrupt exit executed
  input  wire logic             subroutine_exit_i,          // plain return executed
  input  wire logic             low_power_i,                // core in sleep or idle
  output logic                  call_req_o,                 // call to vector, pulse
  output logic [VEC_W-1:0]      call_vector_o,              // vector of last call
  output logic                  push_pc_o,                  // push pc only, pulse
  output logic                  pop_pc_o,                   // pop pc, pulse
  output logic                  wake_o,                     // wake-up, pulse
  output logic                  global_irq_enable_o,        // global enable state
  output logic [NFLG-1:0]       irq_flags_o,                // request flags
  output logic                  irq_pending_o               // an enabled request waits
);

  // ==========================================================
  // uart merger
  logic uart_irq_n;

  uart_irq_merge #(
    .NUM_EV       (NUEV)
  ) u_merge (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .uart_cond_i  (uart_cond_i),
    .uart_irq_n_o (uart_irq_n)
  );

  // ==========================================================
  // helpers
  function automatic logic [VEC_W-1:0] vec_of(input logic [3:0] idx);
    logic [VEC_W-1:0] v;
    v = VEC_W'(`VEC_NONE);
    if (idx == `FLG_LVD) begin
      v = VEC_W'(`VEC_LVD);
    end else if (idx == `FLG_EE) begin
      v = VEC_W'(`VEC_EE);
    end else if (idx == `FLG_T0A) begin
      v = VEC_W'(`VEC_T0A);
    end else if (idx == `FLG_T0P) begin
      v = VEC_W'(`VEC_T0P);
    end else if (idx == `FLG_PA) begin
      v = VEC_W'(`VEC_PA);
    end else if (idx == `FLG_PP) begin
      v = VEC_W'(`VEC_PP);
    end else if (idx == `FLG_MF) begin
      v = VEC_W'(`VEC_MF);
    end
    return v;
  endfunction

  // ==========================================================
  // state
  irq_state_t s_q;
  irq_state_t s_d;

  logic [NFLG-1:0] hw_set;
  logic [NFLG-1:0] req;
  logic [NFLG-1:0] svc_clr;
  logic            mf_member;
  logic            take;
  logic [3:0]      win;
  logic            win_ok;
  logic [3:0]      order [7];

  // service order, lowest vector first
  assign order[0] = `FLG_LVD;
  assign order[1] = `FLG_EE;
  assign order[2] = `FLG_T0A;
  assign order[3] = `FLG_T0P;
  assign order[4] = `FLG_PA;
  assign order[5] = `FLG_PP;
  assign order[6] = `FLG_MF;

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;

    // supply low comes from analog logic, so it is synchronised first
    s_d.lvd_sync1 = supply_low_detector_i;
    s_d.lvd_sync2 = s_q.lvd_sync1;

    // hardware set events
    hw_set               = '0;
    hw_set[`FLG_UART]    = ~uart_irq_n;
    hw_set[`FLG_T1A]     = timer1_match_a_i;
    hw_set[`FLG_T1P]     = timer1_match_p_i;
    hw_set[`FLG_LVD]     = s_q.lvd_sync2;
    hw_set[`FLG_EE]      = eeprom_write_end_i;
    hw_set[`FLG_T0A]     = timer0_match_a_i;
    hw_set[`FLG_T0P]     = timer0_match_p_i;
    hw_set[`FLG_PA]      = periodic_match_a_i;
    hw_set[`FLG_PP]      = periodic_match_p_i;
    // shared flag follows a member flag going high, from any cause
    hw_set[`FLG_MF]      = (hw_set[`FLG_UART] | flag_set_i[`FLG_UART]) & ~s_q.flags[`FLG_UART]
                         | (hw_set[`FLG_T1A] | flag_set_i[`FLG_T1A]) & ~s_q.flags[`FLG_T1A]
                         | (hw_set[`FLG_T1P] | flag_set_i[`FLG_T1P]) & ~s_q.flags[`FLG_T1P];

    // enabled requests; flags themselves ignore the enables
    req = s_q.flags & irq_enable_i;
    mf_member = req[`FLG_UART] | req[`FLG_T1A] | req[`FLG_T1P];
    req[`FLG_UART] = 1'b0;
    req[`FLG_T1A]  = 1'b0;
    req[`FLG_T1P]  = 1'b0;
    req[`FLG_MF]   = req[`FLG_MF] & mf_member;

    // fixed priority pick
    win    = `FLG_MF;
    win_ok = 1'b0;
    for (int i = 6; i >= 0; i--) begin
      if (req[order[i]]) begin
        win    = order[i];
        win_ok = 1'b1;
      end
    end

    // only while the stack has room, otherwise the request pends
    take = win_ok & s_q.gie & core_ready_i & ~stack_full_i
         & ~s_q.call_req;

    // service clears exactly the serviced flag; member flags survive
    svc_clr = '0;
    if (take) begin
      svc_clr[win] = 1'b1;
    end

    // set wins over any clear in the same cycle
    s_d.flags = (s_q.flags & ~(flag_clr_i | svc_clr)) | hw_set | flag_set_i;

    // pulses default low
    s_d.call_req = 1'b0;
    s_d.push_pc  = 1'b0;
    s_d.pop_pc   = 1'b0;

    // global enable: software, then returns, then service
    if (global_irq_enable_set_i) begin
      s_d.gie = 1'b1;
    end else if (global_irq_enable_clr_i) begin
      s_d.gie = 1'b0;
    end
    if (irq_exit_reenable_i) begin
      s_d.pop_pc = 1'b1;
      s_d.gie    = 1'b1;
    end else if (subroutine_exit_i) begin
      s_d.pop_pc = 1'b1;
    end
    if (take) begin
      s_d.gie      = 1'b0;
      s_d.call_req = 1'b1;
      s_d.push_pc  = 1'b1;
      s_d.vector   = vec_of(win);
    end
    // uart event status lives in the uart and has no clear path from here

    // wake on any rising flag, enables play no part
    s_d.flags_prev = s_q.flags;
    s_d.wake = low_power_i & |(s_q.flags & ~s_q.flags_prev);

    s_d.pending = win_ok & s_q.gie;
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      s_q.lvd_sync1  <= 1'b0;
      s_q.lvd_sync2  <= 1'b0;
      s_q.gie        <= `RST_GIE;
      s_q.flags      <= `RST_FLAGS;
      s_q.flags_prev <= `RST_FLAGS;
      s_q.call_req   <= 1'b0;
      s_q.vector     <= VEC_W'(`VEC_NONE);
      s_q.push_pc    <= 1'b0;
      s_q.pop_pc     <= 1'b0;
      s_q.wake       <= 1'b0;
      s_q.pending    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign call_req_o          = s_q.call_req;
  assign call_vector_o       = s_q.vector;
  assign push_pc_o           = s_q.push_pc;
  assign pop_pc_o            = s_q.pop_pc;
  assign wake_o              = s_q.wake;
  assign global_irq_enable_o = s_q.gie;
  assign irq_flags_o         = s_q.flags;
  assign irq_pending_o       = s_q.pending;

endmodule

// *** testbench/irq_properties.sv ***
module irq_properties import irq_pkg::*; #(
  parameter int NFLG = 10,
  parameter int NUEV = 6
) (
  input wire logic            ref_clk_i,
  input wire logic            rstn_i,
  input wire logic [NUEV-1:0] uart_cond_i,
  input wire logic            supply_low_detector_i,
  input wire logic            eeprom_write_end_i,
  input wire logic            timer0_match_a_i,
  input wire logic [NFLG-1:0] flag_clr_i,
  input wire logic            global_irq_enable_set_i,
  input wire logic            core_ready_i,
  input wire logic            stack_full_i,
  input wire logic            irq_exit_reenable_i,
  input wire logic            subroutine_exit_i,
  input wire logic            low_power_i,
  input wire logic            call_req_o,
  input wire logic            push_pc_o,
  input wire logic            pop_pc_o,
  input wire logic            wake_o,
  input wire logic            global_irq_enable_o,
  input wire logic [NFLG-1:0] irq_flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // call and return
  sequence s_call;
    call_req_o && push_pc_o;
  endsequence
  sequence s_rise;
    |(irq_flags_o & ~$past(irq_flags_o));
  endsequence
  a_call_push: assert property (call_req_o |-> s_call)
    else $error("call without pc push");
  a_call_gated: assert property (call_req_o |-> $past(global_irq_enable_o) &&
    $past(core_ready_i) && !$past(stack_full_i)) else $error("call taken while blocked");
  a_call_clears: assert property (s_call |-> !global_irq_enable_o)
    else $error("global enable kept on a call");
  a_exit_reenable: assert property (irq_exit_reenable_i |=> pop_pc_o &&
    (global_irq_enable_o || call_req_o)) else $error("interrupt exit failed");
  a_plain_exit: assert property (subroutine_exit_i && !irq_exit_reenable_i &&
    !global_irq_enable_set_i && !global_irq_enable_o |=> pop_pc_o && !global_irq_enable_o)
    else $error("plain return misbehaved");
  // ==========================================================
  // flags
  a_t1_sticky: assert property (irq_flags_o[1] && !flag_clr_i[1] |=> irq_flags_o[1])
    else $error("timer 1 flag dropped");
  a_uart_sticky: assert property (irq_flags_o[0] && !flag_clr_i[0] |=> irq_flags_o[0])
    else $error("uart flag dropped");
  a_shared_member: assert property ($rose(irq_flags_o[0]) || $rose(irq_flags_o[1]) ||
    $rose(irq_flags_o[2]) |-> irq_flags_o[3]) else $error("shared flag not set");
  a_timer_event: assert property (timer0_match_a_i |=> irq_flags_o[6])
    else $error("timer 0 flag not set");
  a_eeprom_event: assert property (eeprom_write_end_i |=> irq_flags_o[5])
    else $error("eeprom flag not set");
  a_supply_low: assert property (supply_low_detector_i [*3] |=> irq_flags_o[4])
    else $error("supply low flag not set");
  a_uart_request: assert property (|(uart_cond_i & ~$past(uart_cond_i)) |->
    ##[1:3] irq_flags_o[0]) else $error("uart flag not set");
  a_wake_rise: assert property (s_rise ##0 low_power_i |=> wake_o)
    else $error("no wake on flag rise");
endmodule

bind peripheral_interrupt_logic irq_properties #(.NFLG(NFLG), .NUEV(NUEV)) u_props (
  .ref_clk_i               (ref_clk_i),
  .rstn_i                  (rstn_i),
  .uart_cond_i             (uart_cond_i),
  .supply_low_detector_i   (supply_low_detector_i),
  .eeprom_write_end_i      (eeprom_write_end_i),
  .timer0_match_a_i        (timer0_match_a_i),
  .flag_clr_i              (flag_clr_i),
  .global_irq_enable_set_i (global_irq_enable_set_i),
  .core_ready_i            (core_ready_i),
  .stack_full_i            (stack_full_i),
  .irq_exit_reenable_i     (irq_exit_reenable_i),
  .subroutine_exit_i       (subroutine_exit_i),
  .low_power_i             (low_power_i),
  .call_req_o              (call_req_o),
  .push_pc_o               (push_pc_o),
  .pop_pc_o                (pop_pc_o),
  .wake_o                  (wake_o),
  .global_irq_enable_o     (global_irq_enable_o),
  .irq_flags_o             (irq_flags_o)
);

// *** testbench/core_model.sv ***
module core_model (
  input  wire logic ref_clk_i, // system clock
  input  wire logic rstn_i,    // sync reset, active low
  input  wire logic push_i,    // pc pushed by a call
  input  wire logic pop_i,     // pc popped by a return
  input  wire logic busy_i,    // bench stalls the core
  output logic      ready_o,   // instruction boundary
  output logic      full_o     // return stack full
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 4;
  int   depth;
  logic call_q;
  // a call takes a second instruction cycle, so no boundary right after it
  assign ready_o = !busy_i && !call_q;
  assign full_o  = depth >= DEPTH;
  always @(posedge ref_clk_i) begin
    call_q <= push_i;
    if (!rstn_i)
      depth <= 0;
    else
      depth <= depth + int'(push_i) - int'(pop_i && depth > 0);
  end
endmodule

// *** testbench/testbench.sv ***
`include "irq_cfg.svh"
module testbench import irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 0, rstn_i = 0, gset = 0, gclr = 0, irq_exit_reenable = 0, ret = 0, lowp = 0, busy = 0;
  logic [5:0] ucond = '0;
  logic [9:0] hw = '0, fset = '0, fclr = '0, en = '0, flags;
  logic       call, push, pop, wake, gie, pend, ready, full;
  logic [7:0] vec;
  int miscompares = 0, n_compared = 0, cycles = 0, wakes = 0, k;
  int order[9] = '{4, 5, 6, 7, 8, 9, 1, 2, 0};
  always #2.5 ref_clk_i = ~ref_clk_i;
  peripheral_interrupt_logic u_peripheral_interrupt_logic (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .uart_cond_i(ucond),
    .supply_low_detector_i(hw[4]), .eeprom_write_end_i(hw[5]),
    .timer0_match_a_i(hw[6]), .timer0_match_p_i(hw[7]), .timer1_match_a_i(hw[1]),
    .timer1_match_p_i(hw[2]), .periodic_match_a_i(hw[8]), .periodic_match_p_i(hw[9]),
    .flag_set_i(fset), .flag_clr_i(fclr), .irq_enable_i(en), .global_irq_enable_set_i(gset),
    .global_irq_enable_clr_i(gclr), .core_ready_i(ready), .stack_full_i(full),
    .irq_exit_reenable_i(irq_exit_reenable), .subroutine_exit_i(ret), .low_power_i(lowp),
    .call_req_o(call), .call_vector_o(vec), .push_pc_o(push), .pop_pc_o(pop), .wake_o(wake),
    .global_irq_enable_o(gie), .irq_flags_o(flags), .irq_pending_o(pend));
  core_model u_core_model (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .push_i(push), .pop_i(pop),
    .busy_i(busy), .ready_o(ready), .full_o(full));
  always @(posedge ref_clk_i) begin
    cycles++;
    wakes += int'(wake === 1'b1);
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] vec_of(int f);
    case (f)
      4: return `VEC_LVD;
      5: return `VEC_EE;
      6: return `VEC_T0A;
      7: return `VEC_T0P;
      8: return `VEC_PA;
      9: return `VEC_PP;
      default: return `VEC_MF;
    endcase
  endfunction
  task automatic tick(int n = 1);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic pulse(ref logic [9:0] v, input logic [9:0] val);
    v = val;
    tick();
    v = '0;
  endtask
  task automatic gie_pulse(logic set);
    gset = set;
    gclr = !set;
    tick();
    gset = 0;
    gclr = 0;
  endtask
  task automatic expect_call(logic [7:0] v, logic [9:0] fl);
    for (int i = 0; i < 12 && call !== 1'b1; i++) @(posedge ref_clk_i) #1;
    chk("call", 1, call);
    chk("push", 1, push);
    chk("vector", v, vec);
    chk("flags", fl, flags);
    chk("gie", 0, gie);
    tick();
  endtask
  task automatic leave(logic reen);
    logic g;
    g = gie;
    irq_exit_reenable = reen;
    ret = !reen;
    tick();
    irq_exit_reenable = 0;
    ret = 0;
    chk("pop", 1, pop);
    chk("gie", reen | g, gie);
    // one idle edge so back-to-back returns never rewrite a strobe in one step
    tick();
  endtask
  initial begin
    void'($urandom(10425));
    tick(12);
    rstn_i = 1;
    tick();
    chk("reset flags", `RST_FLAGS, flags);
    chk("reset vector", `VEC_NONE, vec);
    pulse(fclr, '1);
    // ==========================================================
    // every source alone, through its hardware event
    foreach (order[i]) begin
      k = order[i];
      en = (10'h1 << k) | (k < 3 ? 10'h8 : 10'h0);
      gset = 1;
      tick();
      gset = 0;
      if (k == 0)
        ucond[$urandom % 6] = 1'b1;
      pulse(hw, k == 0 ? 10'h0 : 10'h1 << k);
      ucond = '0;
      expect_call(vec_of(k), k < 3 ? 10'h1 << k : 10'h0);
      leave(1);
      pulse(fclr, '1);
    end
    // ==========================================================
    // two pending: lower vector first, plain return keeps global off
    en = 10'h220;
    pulse(fset, 10'h220);
    gie_pulse(1);
    expect_call(`VEC_EE, 10'h200);
    leave(0);
    tick(4);
    chk("call", 0, call);
    gie_pulse(1);
    expect_call(`VEC_PP, 10'h0);
    leave(1);
    // ==========================================================
    // fill the return stack, then a request must wait for a pop
    en = 10'h020;
    repeat (5) begin
      pulse(fset, 10'h020);
      gie_pulse(1);
      if (full === 1'b0)
        expect_call(`VEC_EE, 10'h0);
    end
    tick(6);
    chk("call", 0, call);
    chk("pending", 1, pend);
    leave(0);
    expect_call(`VEC_EE, 10'h0);
    repeat (4) leave(1);
    // ==========================================================
    // disabled flag stays set; wake on a rise only
    en = '0;
    lowp = 1;
    wakes = 0;
    pulse(fset, 10'h040);
    tick(4);
    chk("flags", 10'h040, flags);
    chk("wakes", 1, wakes);
    pulse(fset, 10'h040);
    tick(4);
    chk("wakes", 1, wakes);
    gie_pulse(0);
    chk("gie", 0, gie);
    // ==========================================================
    // random traffic, properties watch it
    repeat (400) begin
      hw = 10'($urandom) & 10'($urandom) & 10'($urandom);
      ucond = 6'($urandom);
      en = 10'($urandom);
      busy = 1'($urandom);
      lowp = 1'($urandom);
      gset = ($urandom % 8) == 0;
      irq_exit_reenable = ($urandom % 16) == 0;
      fclr = 10'($urandom) & 10'($urandom);
      tick();
    end
    wrap_up();
  end
endmodule
